//--- fsro_host.sv
`timescale 1ns/100ps
`default_nettype none
module fsro_host
    import fsro_pkg::*;
(
    // Serial lines toward the device
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input  wire logic i_so
);
    // Clock parked low, select idle
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // One frame, MSB first; SCK of 6 ns runs only inside it
    task automatic xfer(input logic [23:0] d, input int n,
                        output logic [15:0] q);
        q = 16'h0000;
        o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_si = d[23 - i];
            #3;
            // Bit launched on the previous rise
            if (i >= 8) q = {q[14:0], i_so};
            o_sck = 1'b1;
            #3;
            o_sck = 1'b0;
        end
        #3;
        o_cs_n = 1'b1;
        o_si = ~o_si; // Released line must not hold its value
        #60; // Deselect gap above 40 ns
    endtask
endmodule
`default_nettype wire

//--- fsro_pkg.sv
`default_nettype none
package fsro_pkg;

    // Command opcodes that the block decodes
    localparam logic [7:0] OPC_WRITE_REGS     = 8'h01;
    localparam logic [7:0] OPC_PROGRAM        = 8'h02;
    localparam logic [7:0] OPC_CLEAR_LATCH    = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS1   = 8'h05;
    localparam logic [7:0] OPC_SET_LATCH      = 8'h06;
    localparam logic [7:0] OPC_READ_STATUS2   = 8'h07;
    localparam logic [7:0] OPC_CLEAR_STATUS   = 8'h30;
    localparam logic [7:0] OPC_BULK_ERASE     = 8'h60;
    localparam logic [7:0] OPC_ERASE_SUSPEND  = 8'h75;
    localparam logic [7:0] OPC_PROG_SUSPEND   = 8'h85;
    localparam logic [7:0] OPC_SECTOR_ERASE   = 8'hD8;
    localparam logic [7:0] OPC_SOFT_RESET     = 8'hF0;

    // Status register one bit positions
    localparam int unsigned SR_LOCK_BIT  = 7;
    localparam int unsigned SR_PERR_BIT  = 6;
    localparam int unsigned SR_EERR_BIT  = 5;
    localparam int unsigned SR_BP_HI     = 4;
    localparam int unsigned SR_BP_LO     = 2;
    localparam int unsigned SR_LATCH_BIT = 1;
    localparam int unsigned SR_BUSY_BIT  = 0;

    // Configuration register one bit positions
    localparam int unsigned CR_PERSIST_BIT = 3;
    localparam int unsigned CR_FREEZE_BIT  = 0;

    // Values after reset
    localparam logic [7:0] SR_RESET_VALUE  = 8'h00;
    localparam logic [7:0] CR_RESET_VALUE  = 8'h00;
    localparam logic [7:0] STAT_TWO_VALUE  = 8'h00;
    localparam logic [2:0] BP_VOL_DEFAULT  = 3'h7;
    localparam logic [2:0] BP_NV_SHIPPED   = 3'h0;

    // Serial bit counts of a frame
    localparam logic [4:0] CMD_BITS        = 5'h08;
    localparam logic [4:0] WREG_SHORT_BITS = 5'h10;
    localparam logic [4:0] WREG_LONG_BITS  = 5'h18;

    // Operation kinds handed to the array engine
    localparam logic [2:0] KIND_NONE       = 3'h0;
    localparam logic [2:0] KIND_PROGRAM    = 3'h1;
    localparam logic [2:0] KIND_ERASE      = 3'h2;
    localparam logic [2:0] KIND_BULK       = 3'h3;
    localparam logic [2:0] KIND_WRITE_REGS = 3'h4;

    // Core operating phase
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_BUSY,
        PH_FAULT
    } fsro_phase_t;

endpackage
`default_nettype wire

//--- fsro_status_one.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Lock set and protect pin low: write-registers ignored entirely.
// - Lock clear or protect pin high: write-registers change lock and BP.
// - Program failure or protected/locked target sets program error flag.
// - Erase failure or single protected sector sets erase error flag.
// - Bulk erase meeting a protected sector leaves the erase error clear.
// - Error flags ignore write-registers; only clear-status and soft reset clear them.
// - BP bits volatile, default 1, when persistence bit is 1, else kept.
// - Nonzero BP bits make program and erase of protected area rejected.
// - Bulk erase runs only when all three BP bits are 0.
// - Write-registers, program and erase accepted only while latch is 1.
// - Set-latch command sets the write latch, clear-latch clears it.
// - Successful program, register write or erase clears the write latch.
// - Latch is 0 after any reset; write-registers data bits never write it.
// - Busy bit reads 1 during any operation, 0 otherwise, read-only.
// - Busy: only status reads, suspends, clear-status, soft reset act.
// - Erase suspend only during erase, program suspend only in program.
// - Errors update while busy; an error keeps busy until clear-status or soft reset.
// - Read-status-one returns the register; write-registers updates it.
// - Persistence bit 1 selects volatile BP bits, 0 selects kept ones.
// - Freeze bit holds BP bits unchanged.
// - Sixteen data bits on write-registers also update config register.
module fsro_status_one
    import fsro_pkg::*;
(
    // Core clock and reset
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RESET_N,
    // Serial link
    input  wire logic       I_SCK,
    input  wire logic       I_CS_N,
    input  wire logic       I_SI,
    output logic            O_SO,
    output logic            O_SO_OE,
    input  wire logic       I_WP_N,
    // Array engine handshake
    output logic            O_OP_START,
    output logic      [2:0] O_OP_KIND,
    output logic            O_SUSPEND,
    output logic            O_SOFT_RESET,
    input  wire logic       I_OP_DONE,
    input  wire logic       I_OP_FAIL,
    input  wire logic       I_OP_PROT,
    // Register contents
    output logic      [7:0] O_STATUS_ONE,
    output logic      [7:0] O_CONFIG_ONE
);

    // Link state kept across frames, cleared only by device reset
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] opcode;
        logic [15:0] data;
        logic [7:0] out_sh;
        logic [2:0] out_cnt;
        logic       tog;
    } fsro_link_t;

    // Link state cleared whenever chip select goes high
    typedef struct packed {
        logic active;
        logic so;
        logic oe;
    } fsro_frame_t;

    // Core state
    typedef struct packed {
        fsro_phase_t phase;
        logic [7:0]  sr;
        logic [7:0]  cfg;
        logic [2:0]  nv_bp;
        logic [2:0]  kind;
        logic        op_start;
        logic        suspend;
        logic        soft_rst;
        logic        cs_prev;
        logic        tog_seen;
    } fsro_core_t;

    fsro_link_t  lk;
    fsro_link_t  next_lk;
    fsro_frame_t fr;
    fsro_frame_t next_fr;
    fsro_core_t  c;
    fsro_core_t  next_c;

    logic       frame_rst_n;
    logic [7:0] sr_link;
    logic       cs_core;
    logic       wp_core;

    // Frame logic restarts on every chip select, since the link clock
    // stands still between frames and cannot end a frame by itself
    assign frame_rst_n = I_RESET_N & ~I_CS_N;

    // Status byte into the link domain, bitwise quasi-static
    fsro_sync2 #(
        .WIDTH       (8),
        .RESET_VALUE (SR_RESET_VALUE)
    ) u_sr_sync (
        .i_clk     (I_SCK),
        .i_reset_n (I_RESET_N),
        .i_async   (c.sr),
        .o_sync    (sr_link)
    );

    // Chip select into the core domain
    fsro_sync2 #(
        .WIDTH       (1),
        .RESET_VALUE (1'b1)
    ) u_cs_sync (
        .i_clk     (I_REF_CLK),
        .i_reset_n (I_RESET_N),
        .i_async   (I_CS_N),
        .o_sync    (cs_core)
    );

    // Write-protect pin into the core domain
    fsro_sync2 #(
        .WIDTH       (1),
        .RESET_VALUE (1'b1)
    ) u_wp_sync (
        .i_clk     (I_REF_CLK),
        .i_reset_n (I_RESET_N),
        .i_async   (I_WP_N),
        .o_sync    (wp_core)
    );

    // Link side: shift in opcode and data, shift out status
    always_comb begin
        logic [4:0] cnt_eff;
        logic [7:0] src;
        cnt_eff = fr.active ? lk.cnt : 5'h00;
        src     = 8'h00;
        next_lk = lk;
        next_fr = fr;
        next_fr.active = 1'b1;
        if (!fr.active) begin
            next_lk.tog = ~lk.tog;  // Marks a new frame for the core
        end
        if (cnt_eff < CMD_BITS) begin
            next_lk.opcode = {lk.opcode[6:0], I_SI};
        end else if (cnt_eff < WREG_LONG_BITS) begin
            next_lk.data = {lk.data[14:0], I_SI};
        end
        if (cnt_eff < WREG_LONG_BITS) begin
            next_lk.cnt = cnt_eff + 5'h01;
        end else begin
            next_lk.cnt = cnt_eff;  // Saturate, extra bits unused
        end
        if (next_lk.opcode == OPC_READ_STATUS1) begin
            src = sr_link;
        end else begin
            src = STAT_TWO_VALUE;
        end
        if (cnt_eff == CMD_BITS - 5'h01 &&
            (next_lk.opcode == OPC_READ_STATUS1 ||
             next_lk.opcode == OPC_READ_STATUS2)) begin
            next_fr.oe      = 1'b1;
            next_fr.so      = src[7];
            next_lk.out_sh  = {src[6:0], 1'b0};
            next_lk.out_cnt = 3'h1;
        end else if (fr.oe && lk.out_cnt == 3'h0) begin
            next_fr.so      = src[7];
            next_lk.out_sh  = {src[6:0], 1'b0};
            next_lk.out_cnt = 3'h1;
        end else if (fr.oe) begin
            next_fr.so      = lk.out_sh[7];
            next_lk.out_sh  = {lk.out_sh[6:0], 1'b0};
            next_lk.out_cnt = lk.out_cnt + 3'h1;
        end
    end

    // Link registers kept between frames
    always_ff @(posedge I_SCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // Link registers that end with the frame
    always_ff @(posedge I_SCK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fr <= '0;
        end else begin
            fr <= next_fr;
        end
    end

    // Core side: execute a frame once chip select has risen
    always_comb begin
        logic       frame_end;
        logic       idle;
        logic       latch_on;
        logic       persist;
        logic       freeze;
        logic [2:0] bp;
        logic [7:0] wsr;
        logic       err_p;
        logic       err_e;
        logic       whole;
        frame_end = 1'b0;
        idle      = 1'b0;
        latch_on  = 1'b0;
        persist   = 1'b0;
        freeze    = 1'b0;
        bp        = 3'h0;
        wsr       = 8'h00;
        err_p     = 1'b0;
        err_e     = 1'b0;
        whole     = 1'b0;
        next_c = c;
        next_c.op_start = 1'b0;
        next_c.suspend  = 1'b0;
        next_c.soft_rst = 1'b0;
        next_c.cs_prev  = cs_core;
        // Link fields are stable while chip select is high
        frame_end = cs_core && !c.cs_prev && (lk.tog != c.tog_seen);
        if (frame_end) begin
            next_c.tog_seen = lk.tog;
        end
        idle    = (c.phase == PH_IDLE);
        latch_on = c.sr[SR_LATCH_BIT];
        persist = c.cfg[CR_PERSIST_BIT];
        freeze  = c.cfg[CR_FREEZE_BIT];
        bp      = c.sr[SR_BP_HI:SR_BP_LO];
        whole   = (lk.cnt[2:0] == 3'h0) && (lk.cnt >= CMD_BITS);
        wsr     = (lk.cnt == WREG_LONG_BITS) ? lk.data[15:8] : lk.data[7:0];

        if (frame_end && whole) begin
            case (lk.opcode)
                OPC_SET_LATCH: begin
                    if (idle) begin
                        next_c.sr[SR_LATCH_BIT] = 1'b1;
                    end
                end
                OPC_CLEAR_LATCH: begin
                    if (idle) begin
                        next_c.sr[SR_LATCH_BIT] = 1'b0;
                    end
                end
                OPC_WRITE_REGS: begin
                    if (idle && latch_on &&
                        (lk.cnt == WREG_SHORT_BITS ||
                         lk.cnt == WREG_LONG_BITS) &&
                        !(c.sr[SR_LOCK_BIT] && !wp_core)) begin
                        next_c.sr[SR_LOCK_BIT] = wsr[SR_LOCK_BIT];
                        if (!freeze) begin
                            next_c.sr[SR_BP_HI:SR_BP_LO] =
                                wsr[SR_BP_HI:SR_BP_LO];
                            if (!persist) begin
                                next_c.nv_bp = wsr[SR_BP_HI:SR_BP_LO];
                            end
                        end
                        if (lk.cnt == WREG_LONG_BITS) begin
                            next_c.cfg = lk.data[7:0];
                            // One-way and freeze-only-set bits
                            next_c.cfg[CR_PERSIST_BIT] =
                                persist | lk.data[CR_PERSIST_BIT];
                            next_c.cfg[CR_FREEZE_BIT] =
                                freeze | lk.data[CR_FREEZE_BIT];
                        end
                        next_c.kind     = KIND_WRITE_REGS;
                        next_c.op_start = 1'b1;
                        next_c.phase    = PH_BUSY;
                    end
                end
                OPC_PROGRAM: begin
                    if (idle && latch_on) begin
                        next_c.kind     = KIND_PROGRAM;
                        next_c.op_start = 1'b1;
                        next_c.phase    = PH_BUSY;
                    end
                end
                OPC_SECTOR_ERASE: begin
                    if (idle && latch_on) begin
                        next_c.kind     = KIND_ERASE;
                        next_c.op_start = 1'b1;
                        next_c.phase    = PH_BUSY;
                    end
                end
                OPC_BULK_ERASE: begin
                    if (idle && latch_on && bp == 3'h0) begin
                        next_c.kind     = KIND_BULK;
                        next_c.op_start = 1'b1;
                        next_c.phase    = PH_BUSY;
                    end
                end
                OPC_CLEAR_STATUS: begin
                    // one of two ways out of a fault, with soft reset
                    next_c.sr[SR_PERR_BIT] = 1'b0;
                    next_c.sr[SR_EERR_BIT] = 1'b0;
                    if (c.phase == PH_FAULT) begin
                        next_c.phase = PH_IDLE;
                    end
                end
                OPC_ERASE_SUSPEND: begin
                    if (c.phase == PH_BUSY &&
                        (c.kind == KIND_ERASE || c.kind == KIND_BULK)) begin
                        next_c.suspend = 1'b1;
                    end
                end
                OPC_PROG_SUSPEND: begin
                    if (c.phase == PH_BUSY && c.kind == KIND_PROGRAM) begin
                        next_c.suspend = 1'b1;
                    end
                end
                OPC_SOFT_RESET: begin
                    next_c.sr[SR_LATCH_BIT] = 1'b0;
                    next_c.sr[SR_PERR_BIT] = 1'b0;
                    next_c.sr[SR_EERR_BIT] = 1'b0;
                    // volatile BP default is all ones
                    next_c.sr[SR_BP_HI:SR_BP_LO] =
                        persist ? BP_VOL_DEFAULT : c.nv_bp;
                    next_c.cfg[CR_FREEZE_BIT] = 1'b0;
                    next_c.phase    = PH_IDLE;
                    next_c.kind     = KIND_NONE;
                    next_c.soft_rst = 1'b1;
                end
                default: begin
                    next_c.kind = c.kind;
                end
            endcase
        end

        // Completion from the engine; a set wins over a same-cycle clear-status, but not over a soft reset
        if (c.phase == PH_BUSY && I_OP_DONE && !next_c.soft_rst) begin
            err_p = (c.kind == KIND_PROGRAM) && (I_OP_FAIL || I_OP_PROT);
            err_e = ((c.kind == KIND_ERASE) && (I_OP_FAIL || I_OP_PROT)) ||
                    ((c.kind == KIND_BULK) && I_OP_FAIL);
            if (err_p) begin
                next_c.sr[SR_PERR_BIT] = 1'b1;
            end
            if (err_e) begin
                next_c.sr[SR_EERR_BIT] = 1'b1;
            end
            if (err_p || err_e) begin
                next_c.phase = PH_FAULT;
            end else begin
                next_c.phase = PH_IDLE;
                if (!I_OP_FAIL) begin
                    next_c.sr[SR_LATCH_BIT] = 1'b0;
                end
            end
        end

        next_c.sr[SR_BUSY_BIT] = (next_c.phase != PH_IDLE);
    end

    // Core registers
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            c          <= '0;
            c.phase    <= PH_IDLE;
            // latch and flags clear at power-on
            c.sr       <= SR_RESET_VALUE;
            c.cfg      <= CR_RESET_VALUE;
            c.nv_bp    <= BP_NV_SHIPPED;
            c.kind     <= KIND_NONE;
            c.cs_prev  <= 1'b1;
        end else begin
            c <= next_c;
        end
    end

    // Outputs straight from flip-flops
    assign O_SO         = fr.so;
    assign O_SO_OE      = fr.oe;
    assign O_OP_START   = c.op_start;
    assign O_OP_KIND    = c.kind;
    assign O_SUSPEND    = c.suspend;
    assign O_SOFT_RESET = c.soft_rst;
    assign O_STATUS_ONE = c.sr;
    assign O_CONFIG_ONE = c.cfg;

endmodule
`default_nettype wire

//--- fsro_status_one_props.sv
`timescale 1ns/100ps
`default_nettype none
module fsro_status_one_props
    import fsro_pkg::*;
(
    // Core clock and reset
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RESET_N,
    // Engine handshake
    input  wire logic       I_OP_DONE,
    input  wire logic       I_OP_FAIL,
    input  wire logic       I_OP_PROT,
    input  wire logic       O_OP_START,
    input  wire logic [2:0] O_OP_KIND,
    input  wire logic       O_SUSPEND,
    input  wire logic       O_SOFT_RESET,
    // Register contents
    input  wire logic [7:0] O_STATUS_ONE,
    input  wire logic [7:0] O_CONFIG_ONE
);
    // Status fields watched below
    wire logic       busy  = O_STATUS_ONE[SR_BUSY_BIT];
    wire logic       latch = O_STATUS_ONE[SR_LATCH_BIT];
    wire logic [1:0] errs  = O_STATUS_ONE[6:5];
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Start always shows busy in the same cycle
    property p_start_busy;
        O_OP_START |-> busy && O_OP_KIND != KIND_NONE;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start without busy");
    property p_start_gate;
        O_OP_START |-> $past(latch) && !$past(busy);
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("start while latch clear or busy");
    property p_bulk_bp;
        O_OP_START && O_OP_KIND == KIND_BULK
            |-> $past(O_STATUS_ONE[4:2]) == 3'h0;
    endproperty
    a_bulk_bp: assert property (p_bulk_bp)
        else $error("bulk erase with protection set");
    property p_perr;
        $rose(O_STATUS_ONE[6]) |-> O_OP_KIND == KIND_PROGRAM
            && $past(I_OP_DONE && (I_OP_FAIL || I_OP_PROT));
    endproperty
    a_perr: assert property (p_perr)
        else $error("program error without cause");
    property p_bulk_eerr;
        $rose(O_STATUS_ONE[5]) && O_OP_KIND == KIND_BULK
            |-> $past(I_OP_FAIL);
    endproperty
    a_bulk_eerr: assert property (p_bulk_eerr)
        else $error("bulk erase flagged protected sector");
    property p_err_busy;
        errs != 2'h0 |-> busy;
    endproperty
    a_err_busy: assert property (p_err_busy)
        else $error("error flag without busy");
    property p_done;
        I_OP_DONE && busy && errs == 2'h0 && !I_OP_FAIL && !I_OP_PROT
            |=> !latch && !busy;
    endproperty
    a_done: assert property (p_done)
        else $error("success left latch or busy");
    property p_susp;
        O_SUSPEND |-> busy && errs == 2'h0 && O_OP_KIND != KIND_NONE
            && O_OP_KIND != KIND_WRITE_REGS;
    endproperty
    a_susp: assert property (p_susp)
        else $error("suspend outside array operation");
    property p_soft;
        O_SOFT_RESET |-> ##[0:1] O_STATUS_ONE[6:5] == 2'h0
            && O_STATUS_ONE[1:0] == 2'h0;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset left latch, busy or error");
    property p_freeze;
        O_CONFIG_ONE[0] && $past(O_CONFIG_ONE[0]) |-> $stable(O_STATUS_ONE[4:2]);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("protect bits moved while frozen");
    // Main scenarios reached
    c_wrr: cover property (O_OP_START && O_OP_KIND == KIND_WRITE_REGS);
    c_susp: cover property (O_SUSPEND);
    c_fault: cover property (errs != 2'h0);
endmodule
bind fsro_status_one fsro_status_one_props fsro_status_one_props_i (
    .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_OP_DONE(I_OP_DONE),
    .I_OP_FAIL(I_OP_FAIL), .I_OP_PROT(I_OP_PROT), .O_OP_START(O_OP_START),
    .O_OP_KIND(O_OP_KIND), .O_SUSPEND(O_SUSPEND),
    .O_SOFT_RESET(O_SOFT_RESET), .O_STATUS_ONE(O_STATUS_ONE),
    .O_CONFIG_ONE(O_CONFIG_ONE));
`default_nettype wire

//--- fsro_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module fsro_sync2
    import fsro_pkg::*;
#(
    parameter int unsigned      WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset of the receiving domain
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    // Level from the other domain
    input  wire logic [WIDTH-1:0] i_async,
    // Level safe to use in this domain
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } fsro_sync_t;

    fsro_sync_t r;
    fsro_sync_t next_r;

    // First stage feeds only the second stage
    always_comb begin
        next_r.meta   = i_async;
        next_r.stable = r.meta;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= {RESET_VALUE, RESET_VALUE};
        end else begin
            r <= next_r;
        end
    end

    assign o_sync = r.stable;

endmodule
`default_nettype wire

//--- tb_fsro_status_one.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; \
    if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_fsro_status_one
    import fsro_pkg::*;
;
    logic clk = 0, rst_n = 0, wp_n = 1, done = 0, fail = 0, prot = 0;
    wire logic sck, cs_n, si, so, so_oe, start, susp, srst;
    wire logic [2:0] kind;
    wire logic [7:0] sr, cr;
    int err_total = 0, cmp_count = 0, n_start = 0, n_susp = 0, n_srst = 0;
    logic [15:0] rd;
    always #4 clk = ~clk;
    // Pulses last one cycle, so they are counted
    always @(posedge clk) begin
        if (start === 1'b1) n_start++;
        if (susp === 1'b1) n_susp++;
        if (srst === 1'b1) n_srst++;
    end
    fsro_status_one fsro_status_one_i (
        .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_SCK(sck), .I_CS_N(cs_n),
        .I_SI(si), .O_SO(so), .O_SO_OE(so_oe), .I_WP_N(wp_n),
        .O_OP_START(start), .O_OP_KIND(kind), .O_SUSPEND(susp),
        .O_SOFT_RESET(srst), .I_OP_DONE(done), .I_OP_FAIL(fail),
        .I_OP_PROT(prot), .O_STATUS_ONE(sr), .O_CONFIG_ONE(cr));
    fsro_host fsro_host_i (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));
    // Frame, then time for the core to act
    task automatic cmd(input logic [7:0] op, input logic [15:0] d,
                       input int n);
        fsro_host_i.xfer({op, d}, n, rd);
        repeat (8) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] e);
        cmd(OPC_READ_STATUS1, 16'h0000, 24);
        `CHK("status", e, sr)
        `CHK("status_read", {e, e}, rd)
    endtask
    // Engine completion pulse
    task automatic eng(input logic f, input logic p);
        @(negedge clk);
        {done, fail, prot} = {1'b1, f, p};
        @(negedge clk);
        {done, fail, prot} = 3'h0;
        repeat (3) @(negedge clk);
    endtask
    task automatic conclude();
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        `CHK("config", 8'h00, cr)
        `CHK("so_idle", 2'h0, {so_oe, so})
        chk(8'h00);
        cmd(OPC_WRITE_REGS, 16'hFC00, 16);
        chk(8'h00);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        chk(8'h02);
        cmd(OPC_CLEAR_LATCH, 16'h0000, 8);
        chk(8'h00);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_WRITE_REGS, 16'hFF00, 16);
        chk(8'h9F);
        `CHK("kind", KIND_WRITE_REGS, kind)
        cmd(OPC_READ_STATUS2, 16'h0000, 24);
        `CHK("status_two", 16'h0000, rd)
        eng(0, 0);
        chk(8'h9C);
        wp_n = 0;
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_WRITE_REGS, 16'h0000, 16);
        chk(8'h9E);
        wp_n = 1;
        cmd(OPC_WRITE_REGS, 16'h0400, 16);
        chk(8'h07);
        eng(0, 0);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_BULK_ERASE, 16'h0000, 8);
        chk(8'h06);
        cmd(OPC_WRITE_REGS, 16'h0000, 16);
        eng(0, 0);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_BULK_ERASE, 16'h0000, 8);
        `CHK("kind", KIND_BULK, kind)
        eng(0, 1);
        `CHK("bulk_flags", 2'h0, {sr[5], sr[0]})
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_BULK_ERASE, 16'h0000, 8);
        eng(1, 0);
        chk(8'h23);
        cmd(OPC_CLEAR_STATUS, 16'h0000, 8);
        cmd(OPC_CLEAR_LATCH, 16'h0000, 8);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_PROGRAM, 16'h0000, 24);
        eng(0, 1);
        chk(8'h43);
        cmd(OPC_CLEAR_LATCH, 16'h0000, 8);
        chk(8'h43);
        cmd(OPC_CLEAR_STATUS, 16'h0000, 8);
        chk(8'h02);
        cmd(OPC_CLEAR_LATCH, 16'h0000, 8);
        chk(8'h00);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_SECTOR_ERASE, 16'h0000, 24);
        cmd(OPC_PROG_SUSPEND, 16'h0000, 8);
        `CHK("suspend", 0, n_susp)
        cmd(OPC_ERASE_SUSPEND, 16'h0000, 8);
        `CHK("suspend", 1, n_susp)
        eng(1, 0);
        chk(8'h23);
        cmd(OPC_CLEAR_STATUS, 16'h0000, 8);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_PROGRAM, 16'h0000, 24);
        cmd(OPC_PROG_SUSPEND, 16'h0000, 8);
        `CHK("suspend", 2, n_susp)
        cmd(OPC_SOFT_RESET, 16'h0000, 8);
        chk(8'h00);
        `CHK("soft_reset", 1, n_srst)
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_WRITE_REGS, 16'h0808, 24);
        `CHK("config", 8'h08, cr)
        eng(0, 0);
        cmd(OPC_SOFT_RESET, 16'h0000, 8);
        chk(8'h1C);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_WRITE_REGS, 16'h1C09, 24);
        eng(0, 0);
        cmd(OPC_SET_LATCH, 16'h0000, 8);
        cmd(OPC_WRITE_REGS, 16'h0009, 24);
        chk(8'h1F);
        eng(0, 0);
        `CHK("starts", 11, n_start)
        conclude();
    end
endmodule
`default_nettype wire
